// *** rfad_decode.sv ***
/*
 Register-file address decode with the two working slice pointers and bank select.
 Assumes the instruction decoder gives one request per cycle and holds no data here;
 the answer appears on the response outputs one clock later.
*/
`timescale 1ns/100ps
`include "rfad_map.svh"
module rfad_decode (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   input  wire logic                reqValid,
   input  wire rfad_pkg::rfad_mode_t reqMode,
   input  wire logic [7:0]          reqAddr,
   input  wire logic                reqPair,
   input  wire logic                regWrEn,
   input  wire logic [7:0]          regWrAddr,
   input  wire logic                regWrSetTwo,
   input  wire logic [7:0]          regWrData,
   input  wire logic [7:0]          regRdAddr,
   input  wire logic                regRdSetTwo,
   input  wire logic                setBothOp,
   input  wire logic                setLowOp,
   input  wire logic                setHighOp,
   input  wire logic [7:0]          opData,
   input  wire logic                selectBankZeroOp,
   input  wire logic                selectBankOneOp,
   output logic                     rspValid,
   output logic [7:0]               rspAddr,
   output logic [7:0]               rspAddrLow,
   output logic                     rspSetTwo,
   output logic                     rspBankOne,
   output logic                     rspIllegal,
   output logic                     rdHit,
   output logic [7:0]               rdData,
   output logic [7:0]               workingSlicePointerLow,
   output logic [7:0]               workingSlicePointerHigh,
   output logic                     bankOne
);

   logic [7:0] ptrLow_q;
   logic [7:0] ptrHigh_q;
   logic       bankOne_q;
   logic       rspValid_q;
   logic [7:0] rspAddr_q;
   logic [7:0] rspAddrLow_q;
   logic       rspSetTwo_q;
   logic       rspBankOne_q;
   logic       rspIllegal_q;
   logic       rdHit_q;
   logic [7:0] rdData_q;

   rfad_work_if workBus ();

   function automatic logic [7:0] nextOdd(input logic [7:0] a);
      nextOdd = a | 8'h01;
   endfunction

   wire       isWorkField;
   wire       inUpper;
   wire       toSetTwo;
   wire [7:0] effAddr;
   wire       toBankOne;
   wire       oddPair;
   wire       anyPtrOp;
   wire       wrLowHit;
   wire       wrHighHit;
   wire       rdLowHit;
   wire       rdHighHit;
   wire [7:0] bothHigh;

   // A direct field with upper nibble 1100B is a working operand, so C0H-CFH never decodes directly
   assign isWorkField = (reqMode == rfad_pkg::RFAD_MODE_WORK4) ||
                        ((reqMode == rfad_pkg::RFAD_MODE_REG) && (reqAddr[7:4] == `RFAD_WORK_NIBBLE));
   assign inUpper     = (reqAddr[7:6] == `RFAD_UPPER_TOP);
   // Only indirect and indexed upper addresses select the duplicated set
   assign toSetTwo    = !isWorkField && inUpper &&
                        ((reqMode == rfad_pkg::RFAD_MODE_IND) || (reqMode == rfad_pkg::RFAD_MODE_IDX));

   assign workBus.operand = reqAddr[3:0];
   assign workBus.ptrLow  = ptrLow_q;
   assign workBus.ptrHigh = ptrHigh_q;

   rfad_work_decode u_work (
      .w (workBus)
   );

   // Working results always land in set one, whatever page the rest uses
   assign effAddr   = isWorkField ? workBus.addr : reqAddr;
   assign toBankOne = !toSetTwo && (effAddr[7:5] == `RFAD_BANK_TOP) && bankOne_q;
   assign oddPair   = reqPair && effAddr[0];

   // Pointer ops outrank a plain register write landing in the same cycle
   assign anyPtrOp  = setBothOp || setLowOp || setHighOp;
   assign wrLowHit  = regWrEn && !regWrSetTwo && (regWrAddr == `RFAD_PTR_LOW_ADDR);
   assign wrHighHit = regWrEn && !regWrSetTwo && (regWrAddr == `RFAD_PTR_HIGH_ADDR);
   assign rdLowHit  = !regRdSetTwo && (regRdAddr == `RFAD_PTR_LOW_ADDR);
   assign rdHighHit = !regRdSetTwo && (regRdAddr == `RFAD_PTR_HIGH_ADDR);
   assign bothHigh  = opData + `RFAD_SLICE_STEP;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ptrLow_q <= `RFAD_PTR_LOW_RST;
      end else if (setBothOp || setLowOp) begin
         ptrLow_q <= opData;
      end else if (wrLowHit && !anyPtrOp) begin
         ptrLow_q <= regWrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ptrHigh_q <= `RFAD_PTR_HIGH_RST;
      end else if (setBothOp) begin
         ptrHigh_q <= bothHigh;
      end else if (setHighOp) begin
         ptrHigh_q <= opData;
      end else if (wrHighHit && !anyPtrOp) begin
         ptrHigh_q <= regWrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bankOne_q <= `RFAD_BANK_RST;
      end else if (selectBankOneOp) begin
         bankOne_q <= 1'b1;
      end else if (selectBankZeroOp) begin
         bankOne_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rspValid_q   <= 1'b0;
         rspAddr_q    <= 8'h00;
         rspAddrLow_q <= 8'h00;
         rspSetTwo_q  <= 1'b0;
         rspBankOne_q <= 1'b0;
         rspIllegal_q <= 1'b0;
      end else begin
         rspValid_q   <= reqValid;
         rspAddr_q    <= effAddr;
         rspAddrLow_q <= nextOdd(effAddr);
         rspSetTwo_q  <= toSetTwo;
         rspBankOne_q <= toBankOne;
         rspIllegal_q <= reqValid && oddPair;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdHit_q  <= 1'b0;
         rdData_q <= 8'h00;
      end else begin
         rdHit_q  <= rdLowHit || rdHighHit;
         rdData_q <= rdLowHit ? ptrLow_q : (rdHighHit ? ptrHigh_q : 8'h00);
      end
   end

   assign rspValid                = rspValid_q;
   assign rspAddr                 = rspAddr_q;
   assign rspAddrLow              = rspAddrLow_q;
   assign rspSetTwo               = rspSetTwo_q;
   assign rspBankOne              = rspBankOne_q;
   assign rspIllegal              = rspIllegal_q;
   assign rdHit                   = rdHit_q;
   assign rdData                  = rdData_q;
   assign workingSlicePointerLow  = ptrLow_q;
   assign workingSlicePointerHigh = ptrHigh_q;
   assign bankOne                 = bankOne_q;

   property p_set_two;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && inUpper && ((reqMode == rfad_pkg::RFAD_MODE_IND) || (reqMode == rfad_pkg::RFAD_MODE_IDX)))
      |=> (rspSetTwo_q && rspAddr_q == $past(reqAddr));
   endproperty
   a_set_two: assert property (p_set_two) else $error("upper indirect or indexed access missed set two");

   property p_direct_set_one;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && reqMode == rfad_pkg::RFAD_MODE_REG) |=> !rspSetTwo_q;
   endproperty
   a_direct_set_one: assert property (p_direct_set_one) else $error("direct access reached set two");

   property p_prime;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && !inUpper && reqMode != rfad_pkg::RFAD_MODE_WORK4)
      |=> (rspAddr_q == $past(reqAddr) && !rspSetTwo_q && !rspBankOne_q);
   endproperty
   a_prime: assert property (p_prime) else $error("prime area address altered");

   property p_reset_ptr;
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> (ptrLow_q == `RFAD_PTR_LOW_RST && ptrHigh_q == `RFAD_PTR_HIGH_RST && !bankOne_q);
   endproperty
   a_reset_ptr: assert property (p_reset_ptr) else $error("pointers or bank wrong after reset");

   property p_set_both;
      @(posedge sys_clk) disable iff (!rst_n)
      setBothOp |=> (ptrLow_q == $past(opData) && ptrHigh_q == 8'($past(opData) + 8'h08));
   endproperty
   a_set_both: assert property (p_set_both) else $error("set-both op loaded wrong values");

   property p_work4;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && reqMode == rfad_pkg::RFAD_MODE_WORK4 && !reqAddr[3])
      |=> (rspAddr_q == (($past(ptrLow_q) & 8'hf8) | ($past(reqAddr) & 8'h07)) && !rspSetTwo_q);
   endproperty
   a_work4: assert property (p_work4) else $error("4-bit working address formed wrongly");

   property p_work8;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && reqMode == rfad_pkg::RFAD_MODE_REG && reqAddr[7:4] == 4'hc && reqAddr[3])
      |=> (rspAddr_q == (($past(ptrHigh_q) & 8'hf8) | ($past(reqAddr) & 8'h07)) && !rspSetTwo_q);
   endproperty
   a_work8: assert property (p_work8) else $error("8-bit working address formed wrongly");

   property p_pair;
      @(posedge sys_clk) disable iff (!rst_n)
      (reqValid && reqPair) |=> (rspIllegal_q == rspAddr_q[0] && (rspIllegal_q || rspAddrLow_q == 8'(rspAddr_q + 8'h01)));
   endproperty
   a_pair: assert property (p_pair) else $error("pair check or low byte address wrong");

   property p_ptr_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (regWrEn && !regWrSetTwo && regWrAddr == 8'hd7 && !setBothOp && !setLowOp && !setHighOp)
      ##1 1'b1 ##1 1'b1 |-> $past(ptrHigh_q) == $past(regWrData, 2);
   endproperty
   a_ptr_write: assert property (p_ptr_write) else $error("write to D7H did not load high pointer");

   property p_bank;
      @(posedge sys_clk) disable iff (!rst_n)
      selectBankOneOp |=> (bankOne_q ##1 (!rspBankOne_q || rspAddr_q[7:5] == 3'h7));
   endproperty
   a_bank: assert property (p_bank) else $error("bank one not selected or flagged wrongly");

endmodule

// *** rfad_map.svh ***
/*
 Register-file address decode: offsets, reset values and field codes.
 Assumes inclusion by rfad_work_decode.sv and rfad_decode.sv only.
*/
`ifndef RFAD_MAP_SVH
`define RFAD_MAP_SVH

`define RFAD_PTR_LOW_ADDR   8'hd6
`define RFAD_PTR_HIGH_ADDR  8'hd7
`define RFAD_PTR_LOW_RST    8'hc0
`define RFAD_PTR_HIGH_RST   8'hc8
`define RFAD_SLICE_STEP     8'h08
`define RFAD_SLICE_MASK     8'hf8
`define RFAD_INDEX_MASK     8'h07
`define RFAD_UPPER_TOP      2'h3
`define RFAD_WORK_NIBBLE    4'hc
`define RFAD_BANK_TOP       3'h7
`define RFAD_BANK_RST       1'h0

`endif

// *** rfad_pkg.sv ***
/*
 Types shared by the register-file address decode.
 Assumes the caller writes rfad_pkg::name for every use.
*/
package rfad_pkg;

   typedef enum logic [1:0] {
      RFAD_MODE_REG   = 2'h0,
      RFAD_MODE_IND   = 2'h1,
      RFAD_MODE_IDX   = 2'h2,
      RFAD_MODE_WORK4 = 2'h3
   } rfad_mode_t;

endpackage

// *** rfad_work_if.sv ***
/*
 Carrier between the top decode and its working-register address former.
 Assumes both ends sit on the same clock; the path is combinational.
*/
`timescale 1ns/100ps
interface rfad_work_if;
   logic [3:0] operand;
   logic [7:0] ptrLow;
   logic [7:0] ptrHigh;
   logic [7:0] addr;

   modport dec  (input operand, input ptrLow, input ptrHigh, output addr);
   modport user (output operand, output ptrLow, output ptrHigh, input addr);
endinterface

// *** rfad_work_decode.sv ***
/*
 Working-register address former: slice pointer plus 3-bit register index.
 Assumes the operand nibble is already extracted from a 4-bit or 8-bit field.
*/
`timescale 1ns/100ps
`include "rfad_map.svh"
module rfad_work_decode (
   rfad_work_if.dec w
);

   wire [7:0] selPtr;

   // Top operand bit picks the pointer
   assign selPtr = w.operand[3] ? w.ptrHigh : w.ptrLow;
   // Pointer low bits ignored so slices stay 8-byte aligned
   assign w.addr = (selPtr & `RFAD_SLICE_MASK) | {5'h00, w.operand[2:0]};

endmodule

// *** rfad_cpu_model.sv ***
/*
 CPU-side model: issues decode, pointer, bank and register-port requests.
 Assumes tb calls its tasks; each request lasts one cycle and is launched at a falling edge.
*/
`timescale 1ns/100ps
module rfad_cpu_model (
   input  wire logic            sys_clk,
   output logic                 reqValid,
   output rfad_pkg::rfad_mode_t reqMode,
   output logic [7:0]           reqAddr,
   output logic                 reqPair,
   output logic                 regWrEn,
   output logic [7:0]           regWrAddr,
   output logic                 regWrSetTwo,
   output logic [7:0]           regWrData,
   output logic [7:0]           regRdAddr,
   output logic                 regRdSetTwo,
   output logic                 setBothOp,
   output logic                 setLowOp,
   output logic                 setHighOp,
   output logic [7:0]           opData,
   output logic                 selectBankZeroOp,
   output logic                 selectBankOneOp
);
   initial begin
      {reqValid, reqPair, regWrEn, regWrSetTwo, regRdSetTwo} = 5'h00;
      {setBothOp, setLowOp, setHighOp, selectBankZeroOp, selectBankOneOp} = 5'h00;
      reqMode = rfad_pkg::RFAD_MODE_REG;
      {reqAddr, regWrAddr, regWrData, regRdAddr, opData} = 40'h0;
   end

   // Fields flip on release so a stale value can never pass for a fresh answer
   task automatic dec(input logic [1:0] m, input logic [7:0] a, input logic p);
      @(negedge sys_clk);
      reqMode = rfad_pkg::rfad_mode_t'(m);
      {reqValid, reqAddr, reqPair} = {1'b1, a, p};
      @(negedge sys_clk);
      {reqValid, reqAddr} = {1'b0, ~a};
   endtask

   // Kind 0 both, 1 low, 2 high, 3 bank zero, 4 bank one; w adds a clashing pointer write
   task automatic op(input logic [2:0] k, input logic [7:0] d, input logic w);
      @(negedge sys_clk);
      {setBothOp, setLowOp, setHighOp, selectBankZeroOp, selectBankOneOp} = 5'h10 >> k;
      {opData, regWrEn, regWrAddr, regWrSetTwo, regWrData} = {d, w, 8'hd6, 1'b0, ~d};
      @(negedge sys_clk);
      {setBothOp, setLowOp, setHighOp, selectBankZeroOp, selectBankOneOp, regWrEn} = 6'h00;
      opData = ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic s2, input logic [7:0] d);
      @(negedge sys_clk);
      {regWrEn, regWrAddr, regWrSetTwo, regWrData} = {1'b1, a, s2, d};
      @(negedge sys_clk);
      {regWrEn, regWrData} = {1'b0, ~d};
   endtask

   task automatic rd(input logic [7:0] a, input logic s2);
      @(negedge sys_clk);
      {regRdAddr, regRdSetTwo} = {a, s2};
      @(negedge sys_clk);
      regRdAddr = ~a;
   endtask
endmodule

// *** rfad_tb.sv ***
/*
 Self-checking bench for the register-file address decode.
 Assumes the CPU model drives every request input; the bench clocks, resets and judges.
*/
`timescale 1ns/100ps
module tb;
   logic       sys_clk = 1'b0;
   logic       rst_n = 1'b0;
   rfad_pkg::rfad_mode_t reqMode;
   logic       reqValid, reqPair, regWrEn, regWrSetTwo, regRdSetTwo, setBothOp, setLowOp, setHighOp;
   logic       selectBankZeroOp, selectBankOneOp, rspValid, rspSetTwo, rspBankOne, rspIllegal, rdHit, bankOne;
   logic [7:0] reqAddr, regWrAddr, regWrData, regRdAddr, opData, rspAddr, rspAddrLow, rdData;
   logic [7:0] workingSlicePointerLow, workingSlicePointerHigh, expLo, expHi;
   int         errTotal = 0;
   int         cmpCount = 0;

   always #4 sys_clk = ~sys_clk;

   rfad_cpu_model cpu (.sys_clk, .reqValid, .reqMode, .reqAddr, .reqPair, .regWrEn, .regWrAddr, .regWrSetTwo,
      .regWrData, .regRdAddr, .regRdSetTwo, .setBothOp, .setLowOp, .setHighOp, .opData, .selectBankZeroOp,
      .selectBankOneOp);
   rfad_decode uut (.sys_clk, .rst_n, .reqValid, .reqMode, .reqAddr, .reqPair, .regWrEn, .regWrAddr,
      .regWrSetTwo, .regWrData, .regRdAddr, .regRdSetTwo, .setBothOp, .setLowOp, .setHighOp, .opData,
      .selectBankZeroOp, .selectBankOneOp, .rspValid, .rspAddr, .rspAddrLow, .rspSetTwo, .rspBankOne,
      .rspIllegal, .rdHit, .rdData, .workingSlicePointerLow, .workingSlicePointerHigh, .bankOne);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [7:0] wAddr(input logic [3:0] o);
      wAddr = {(o[3] ? expHi[7:3] : expLo[7:3]), o[2:0]};
   endfunction

   task automatic dec(input logic [1:0] m, input logic [7:0] a, input logic p, input logic [7:0] ea,
                      input logic s2);
      cpu.dec(m, a, p);
      chk(rspValid, 8'h01);
      chk(rspAddr, ea);
      chk(rspSetTwo, s2);
   endtask

   task automatic ptrChk;
      chk(workingSlicePointerLow, expLo);
      chk(workingSlicePointerHigh, expHi);
      cpu.rd(8'hd6, 1'b0);
      chk(rdHit, 8'h01);
      chk(rdData, expLo);
      cpu.rd(8'hd7, 1'b0);
      chk(rdHit, 8'h01);
      chk(rdData, expHi);
   endtask

   task automatic doReset;
      rst_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      {expLo, expHi} = 16'hc0c8;
   endtask

   task automatic t_reset;
      dec(2'h0, 8'h5a, 1'b0, 8'h5a, 1'b0);
      ptrChk();
      chk(bankOne, 8'h00);
   endtask

   task automatic t_work;
      for (int i = 0; i < 16; i++) begin
         dec(2'h3, i[7:0], 1'b0, wAddr(i[3:0]), 1'b0);
         dec(2'h0, {4'hc, i[3:0]}, 1'b0, wAddr(i[3:0]), 1'b0);
      end
   endtask

   task automatic t_sets;
      for (int m = 0; m < 3; m++) begin
         dec(m[1:0], 8'he4, 1'b0, 8'he4, m != 0);
         dec(m[1:0], 8'hbf, 1'b0, 8'hbf, 1'b0);
      end
   endtask

   task automatic t_ptrs;
      cpu.op(3'h0, 8'h70, 1'b0);
      {expLo, expHi} = 16'h7078;
      ptrChk();
      dec(2'h3, 8'h06, 1'b0, 8'h76, 1'b0);
      cpu.op(3'h2, 8'h48, 1'b0);
      cpu.op(3'h1, 8'ha0, 1'b0);
      {expLo, expHi} = 16'ha048;
      ptrChk();
      cpu.wr(8'hd6, 1'b0, 8'h00);
      cpu.wr(8'hd7, 1'b0, 8'hf8);
      cpu.wr(8'hd6, 1'b1, 8'h55);
      cpu.rd(8'hd6, 1'b1);
      chk(rdHit, 8'h00);
      chk(rdData, 8'h00);
      cpu.rd(8'hd5, 1'b0);
      chk(rdHit, 8'h00);
      {expLo, expHi} = 16'h00f8;
      ptrChk();
      cpu.op(3'h1, 8'h8f, 1'b1);
      expLo = 8'h8f;
      ptrChk();
      dec(2'h3, 8'h01, 1'b0, 8'h89, 1'b0);
      cpu.op(3'h0, 8'hf8, 1'b0);
      {expLo, expHi} = 16'hf800;
      ptrChk();
   endtask

   task automatic t_pair;
      dec(2'h0, 8'h40, 1'b1, 8'h40, 1'b0);
      chk(rspAddrLow, 8'h41);
      chk(rspIllegal, 8'h00);
      dec(2'h0, 8'h41, 1'b1, 8'h41, 1'b0);
      chk(rspIllegal, 8'h01);
      dec(2'h3, 8'h0a, 1'b1, wAddr(4'ha), 1'b0);
      chk(rspAddrLow, wAddr(4'ha) | 8'h01);
   endtask

   task automatic t_bank;
      dec(2'h0, 8'he5, 1'b0, 8'he5, 1'b0);
      chk(rspBankOne, 8'h00);
      cpu.op(3'h4, 8'h00, 1'b0);
      chk(bankOne, 8'h01);
      dec(2'h0, 8'he5, 1'b0, 8'he5, 1'b0);
      chk(rspBankOne, 8'h01);
      dec(2'h1, 8'he5, 1'b0, 8'he5, 1'b1);
      chk(rspBankOne, 8'h00);
      doReset();
      ptrChk();
      chk(bankOne, 8'h00);
      cpu.op(3'h4, 8'h00, 1'b0);
      cpu.op(3'h3, 8'h00, 1'b0);
      chk(bankOne, 8'h00);
   endtask

   task automatic finishTest;
      if (errTotal == 0 && cmpCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog: the sequence needs far fewer cycles than this
   initial begin
      #100us;
      errTotal++;
      finishTest();
   end

   initial begin
      doReset();
      t_reset();
      t_work();
      t_sets();
      t_ptrs();
      t_work();
      t_pair();
      t_bank();
      finishTest();
   end
endmodule
